// ### verilog/ratex_pkg.sv
// constants, types and carriers shared by the ratio/expand output chain
// Overview of operation
// - x, y and r offsets are percent of full scale; log offset in dB.
// - phase change rotates the stored x/y offset vector by minus the phase.
// - ratio mode divides x and y by the chosen aux input, either polarity.
// - an aux input of exactly 1.000 V leaves the values unchanged.
// - one ratio mode (off, aux one, aux two) governs x and y together.
// - ratio indicators off when ratio off; channel-two copies mirror them.
// - magnitude is computed from the ratioed x and y; no phase is computed.
// - the in-phase noise source is the ratioed in-phase value.
// - aux one display is never ratioed; no unratioed copies offered.
// - ratio overflow flag when the chosen aux input exceeds 10.5 V.
// - ratio underflow flag when the chosen aux magnitude is under 50 mV.
// - per-quantity expand x1, x10, x100 drives display and analog output.
// - x10 and x100 indicators show the expand; both dark at x1.
// - expanded display keeps value, adds one or two digits, sets flag.
// - expand acts on outputs only, never on magnitude/phase inputs.
// - output overload flag when expanded output exceeds 10.5 V.
// - output select routes the display quantity or x to the output.
// - display mode scales 10 V to full scale with display settings.
// - x mode uses the settings held for x, whatever is displayed.
// - one shared set of x offset, ratio and expand for display and output.
// - display overload above 110 percent of full scale over the expand.
// - x and y offsets switch on and off together as one pair.
package ratex_pkg;
    localparam int DW = 24;
    // full scale of x, y, r in sample counts
    localparam logic signed [23:0] FS_X = 24'sh004000;
    // 200 dB in 0.01 dB steps, and 10 V in mV for the aux quantity
    localparam logic signed [23:0] FS_DB = 24'sh004e20;
    localparam logic signed [23:0] FS_AUX = 24'sh002710;
    localparam logic signed [31:0] PCT_DEN = 32'sh00002710;
    // aux inputs are in mV: 1.000 V, 10.5 V and 50 mV
    localparam logic signed [15:0] AUX_ONE = 16'sh03e8;
    localparam logic signed [15:0] AUX_MAX = 16'sh2904;
    localparam logic signed [15:0] AUX_MIN = 16'sh0032;
    // analog output code in mV: 10 V full scale, 10.5 V limit
    localparam logic signed [47:0] DAC_FS = 48'sh2710;
    localparam logic signed [47:0] DAC_MAX = 48'sh2904;
    localparam logic signed [47:0] OVR_NUM = 48'sh6e;
    localparam logic signed [47:0] OVR_DEN = 48'sh64;
    localparam logic signed [15:0] MUL_X10 = 16'sh000a;
    localparam logic signed [15:0] MUL_X100 = 16'sh0064;
    localparam logic signed [15:0] MUL_X1 = 16'sh0001;
    localparam logic signed [23:0] LOG_STEP = 24'sh00025a;
    localparam logic signed [15:0] COS_ONE = 16'sh4000;
    localparam int ROT_SHIFT = 14;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_EXP = 8'h04;
    localparam logic [7:0] A_XOFF = 8'h08;
    localparam logic [7:0] A_YOFF = 8'h0c;
    localparam logic [7:0] A_ROFF = 8'h10;
    localparam logic [7:0] A_LOFF = 8'h14;
    localparam logic [7:0] A_PHASE = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [1:0] {
        RAT_OFF = 2'h0, RAT_AUX1 = 2'h1, RAT_AUX2 = 2'h2
    } ratex_ratio_t;
    typedef enum logic [2:0] {
        Q_X = 3'h0, Q_R = 3'h1, Q_RLOG = 3'h2, Q_NOISE = 3'h3, Q_AUX1 = 3'h4
    } ratex_qty_t;
    typedef enum logic [1:0] {
        EXP_X1 = 2'h0, EXP_X10 = 2'h1, EXP_X100 = 2'h2
    } ratex_exp_t;
    typedef enum logic {BUS_IDLE = 1'b0, BUS_RESP = 1'b1} ratex_bus_t;
    typedef struct packed {
        logic rlog_off_en;
        logic r_off_en;
        ratex_qty_t dsel;
        logic out_x;
        logic xy_off_en;
        ratex_ratio_t ratio;
    } ratex_ctrl_t;
    typedef struct packed {
        ratex_exp_t noise;
        ratex_exp_t rlog;
        ratex_exp_t r;
        ratex_exp_t x;
    } ratex_exp_set_t;
    typedef struct packed {
        logic signed [15:0] sin_v;
        logic signed [15:0] cos_v;
    } ratex_phase_t;
endpackage

// ### verilog/ratex_ratio.sv
// one ratio lane: divide by the aux input normalised to 1.000 V
module ratex_ratio import ratex_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vin,
    input wire logic en,
    input wire logic signed [15:0] num,
    input wire logic signed [15:0] den,
    output logic vout,
    output logic signed [DW-1:0] q
);
    typedef struct packed {
        logic v;
        logic signed [DW-1:0] q;
    } ratex_lane_t;
    ratex_lane_t s_r, s_nxt;
    localparam logic signed [31:0] QMAX = 32'sh007fffff;

    always_comb begin
        logic signed [31:0] t;
        t = 32'(num);
        s_nxt = s_r;
        s_nxt.v = vin;
        if (vin && en) begin
            // zero divisor pins to the rail with the numerator's sign
            if (den == 16'sh0000)
                t = num[15] ? -QMAX : QMAX;
            else
                t = (32'(num) * 32'(AUX_ONE)) / 32'(den);
            if (t > QMAX)
                t = QMAX;
            if (t < -QMAX)
                t = -QMAX;
        end
        if (vin)
            s_nxt.q = t[DW-1:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign vout = s_r.v;
    assign q = s_r.q;

    chk_unity_ratio: assert property (@(posedge clk)
        disable iff (!rst_n)
        vin && en && den == AUX_ONE |=> q == DW'($past(num)))
        else $error("unit aux input changed the value");
endmodule

// ### verilog/ratex_expand.sv
// expand, scale to the output code, saturate and flag overloads
module ratex_expand import ratex_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [DW-1:0] val,
    input wire ratex_exp_t expand,
    input wire logic signed [DW-1:0] fs,
    output logic signed [15:0] code,
    output logic out_overload_flag,
    output logic disp_overload_flag
);
    typedef struct packed {
        logic signed [15:0] code;
        logic out_overload_flag;
        logic disp_overload_flag;
    } ratex_exo_t;
    ratex_exo_t s_r, s_nxt;

    // expand gain, 10 V at full scale
    always_comb begin
        logic signed [15:0] mul;
        logic signed [47:0] sc;
        logic signed [47:0] dac;
        mul = expand == EXP_X100 ? MUL_X100 :
              expand == EXP_X10 ? MUL_X10 : MUL_X1;
        sc = 48'(val) * 48'(mul);
        // no full scale loaded yet (after reset) gives a zero code, not X
        if (fs == '0)
            dac = '0;
        else
            dac = (sc * DAC_FS) / 48'(fs);
        s_nxt = s_r;
        s_nxt.out_overload_flag = dac > DAC_MAX || dac < -DAC_MAX;
        if (dac > DAC_MAX)
            dac = DAC_MAX;
        else if (dac < -DAC_MAX)
            dac = -DAC_MAX;
        s_nxt.code = dac[15:0];
        s_nxt.disp_overload_flag = (sc * OVR_DEN > 48'(fs) * OVR_NUM) ||
                          (-sc * OVR_DEN > 48'(fs) * OVR_NUM);
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign code = s_r.code;
    assign out_overload_flag = s_r.out_overload_flag;
    assign disp_overload_flag = s_r.disp_overload_flag;

    chk_code_saturates: assert property (@(posedge clk)
        disable iff (!rst_n)
        out_overload_flag |-> code == 16'(DAC_MAX) || code == -16'(DAC_MAX))
        else $error("overloaded output code not at the rail");
endmodule

// ### verilog/ratex_chain.sv
// channel-one output chain: offsets, ratio, magnitude, expand, select
module ratex_chain import ratex_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic IN_VALID,
    input wire logic signed [15:0] IN_X,
    input wire logic signed [15:0] IN_Y,
    input wire logic signed [15:0] AUX1,
    input wire logic signed [15:0] AUX2,
    input wire logic signed [DW-1:0] XNOISE,
    output logic RATIO_VALID,
    output logic signed [DW-1:0] RATIO_X,
    output logic signed [DW-1:0] RATIO_Y,
    output logic signed [15:0] CHANNEL_ONE_ANALOG_OUT,
    output logic OUT_OVERLOAD_FLAG,
    output logic signed [DW-1:0] DISP_VALUE,
    output logic DISP_OVERLOAD_FLAG,
    output logic DISP_EXPAND,
    output logic [1:0] DISP_EXTRA_DIGITS,
    output logic X10_LED,
    output logic X100_LED,
    output logic RATIO_AUX1_LED,
    output logic RATIO_AUX2_LED,
    output logic CH2_AUX1_LED,
    output logic CH2_AUX2_LED,
    output logic RATIO_OVERFLOW,
    output logic RATIO_UNDERFLOW,
    output logic QUAD_OFFSET_ACTIVE_FLAG
);
    typedef struct packed {
        ratex_bus_t wst;
        ratex_bus_t rst;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        ratex_ctrl_t ctrl;
        ratex_exp_set_t exps;
        logic signed [15:0] xoff;
        logic signed [15:0] yoff;
        logic signed [15:0] roff;
        logic signed [15:0] loff;
        ratex_phase_t ph;
        logic signed [15:0] ox;
        logic signed [15:0] oy;
        logic v1;
        logic signed [15:0] x1;
        logic signed [15:0] y1;
        logic signed [DW-1:0] dval;
        logic signed [DW-1:0] dfs;
        ratex_exp_t dexp;
        logic signed [DW-1:0] aval;
        logic signed [DW-1:0] afs;
        ratex_exp_t aexp;
        logic ovf;
        logic unf;
    } ratex_state_t;
    ratex_state_t s_r, s_nxt;

    logic rv;
    logic signed [DW-1:0] xr;
    logic signed [DW-1:0] yr;
    logic signed [15:0] aux_sel;
    logic ratio_on;
    logic do_wr;
    logic do_rd;
    logic [15:0] disp_code_unused;
    logic disp_out_overload_flag_unused;
    logic ana_disp_overload_flag_unused;

    // one ratio mode drives both lanes
    assign ratio_on = s_r.ctrl.ratio == RAT_AUX1 ||
        s_r.ctrl.ratio == RAT_AUX2; // spare code 3 acts as off
    assign aux_sel = s_r.ctrl.ratio == RAT_AUX2 ? AUX2 : AUX1;

    // write address and data are taken together while no answer is pending
    assign do_wr = s_r.wst == BUS_IDLE && AWVALID && WVALID;
    assign do_rd = s_r.rst == BUS_IDLE && ARVALID;
    assign AWREADY = do_wr;
    assign WREADY = do_wr;
    assign ARREADY = s_r.rst == BUS_IDLE;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                m[i*8 +: 8] = d[i*8 +: 8];
        return m;
    endfunction

    // magnitude without a square root: max + 3/8 min is linear in scale
    function automatic logic signed [DW-1:0] mag(
        input logic signed [DW-1:0] a, input logic signed [DW-1:0] b);
        logic signed [DW-1:0] pa;
        logic signed [DW-1:0] pb;
        pa = a < 0 ? -a : a;
        pb = b < 0 ? -b : b;
        if (pa > pb)
            return pa + (pb >>> 2) + (pb >>> 3);
        return pb + (pa >>> 2) + (pa >>> 3);
    endfunction

    // coarse 20log10 in 0.01 dB steps from the leading one position
    function automatic logic signed [DW-1:0] lg(
        input logic signed [DW-1:0] m);
        logic signed [DW-1:0] p;
        p = '0;
        for (int i = 0; i < DW; i++)
            if (m[i])
                p = DW'(i);
        return p * LOG_STEP;
    endfunction

    function automatic logic signed [DW-1:0] pct(input logic signed [15:0] o);
        logic signed [31:0] t;
        t = (32'(o) * 32'(FS_X)) / PCT_DEN;
        return t[DW-1:0];
    endfunction

    always_comb begin
        logic [31:0] cur;
        logic signed [31:0] rx;
        logic signed [31:0] ry;
        logic signed [DW-1:0] rm;
        logic signed [DW-1:0] xv;
        logic [31:0] stat;
        cur = '0;
        rx = '0;
        ry = '0;
        rm = '0;
        xv = '0;
        stat = '0;
        s_nxt = s_r;

        // register writes
        if (do_wr) begin
            s_nxt.wst = BUS_RESP;
            s_nxt.bresp = RESP_OK;
            unique case (AWADDR)
                A_CTRL: begin
                    cur = merge(32'(s_r.ctrl), WDATA, WSTRB);
                    s_nxt.ctrl = cur[$bits(ratex_ctrl_t)-1:0];
                end
                A_EXP: begin
                    cur = merge(32'(s_r.exps), WDATA, WSTRB);
                    s_nxt.exps = cur[$bits(ratex_exp_set_t)-1:0];
                end
                A_XOFF: begin
                    cur = merge(32'(s_r.xoff), WDATA, WSTRB);
                    s_nxt.xoff = cur[15:0];
                end
                A_YOFF: begin
                    cur = merge(32'(s_r.yoff), WDATA, WSTRB);
                    s_nxt.yoff = cur[15:0];
                end
                A_ROFF: begin
                    cur = merge(32'(s_r.roff), WDATA, WSTRB);
                    s_nxt.roff = cur[15:0];
                end
                A_LOFF: begin
                    cur = merge(32'(s_r.loff), WDATA, WSTRB);
                    s_nxt.loff = cur[15:0];
                end
                A_PHASE: s_nxt.ph = merge(s_r.ph, WDATA, WSTRB);
                default: s_nxt.bresp = RESP_ERR;
            endcase
        end else if (s_r.wst == BUS_RESP && BREADY) begin
            s_nxt.wst = BUS_IDLE;
        end

        // status word shows the live ratio, overload and offset-active flags
        stat[0] = s_r.ovf;
        stat[1] = s_r.unf;
        stat[2] = OUT_OVERLOAD_FLAG;
        stat[3] = DISP_OVERLOAD_FLAG;
        stat[4] = QUAD_OFFSET_ACTIVE_FLAG;

        // register reads
        if (do_rd) begin
            s_nxt.rst = BUS_RESP;
            s_nxt.rresp = RESP_OK;
            unique case (ARADDR)
                A_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
                A_EXP: s_nxt.rdata = 32'(s_r.exps);
                A_XOFF: s_nxt.rdata = {16'h0000, s_r.xoff};
                A_YOFF: s_nxt.rdata = {16'h0000, s_r.yoff};
                A_ROFF: s_nxt.rdata = {16'h0000, s_r.roff};
                A_LOFF: s_nxt.rdata = {16'h0000, s_r.loff};
                A_PHASE: s_nxt.rdata = s_r.ph;
                A_STAT: s_nxt.rdata = stat;
                default: begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = RESP_ERR;
                end
            endcase
        end else if (s_r.rst == BUS_RESP && RREADY) begin
            s_nxt.rst = BUS_IDLE;
        end

        // offset vector held in the signal frame, turned by minus phase
        rx = 32'(s_r.xoff) * 32'(s_r.ph.cos_v)
           + 32'(s_r.yoff) * 32'(s_r.ph.sin_v);
        ry = 32'(s_r.yoff) * 32'(s_r.ph.cos_v)
           - 32'(s_r.xoff) * 32'(s_r.ph.sin_v);
        s_nxt.ox = 16'(rx >>> ROT_SHIFT);
        s_nxt.oy = 16'(ry >>> ROT_SHIFT);

        // one enable for the pair; offsets before the ratio
        s_nxt.v1 = IN_VALID;
        if (IN_VALID) begin
            // offset in 0.01 percent of full scale
            s_nxt.x1 = s_r.ctrl.xy_off_en ?
                16'(pct(s_r.ox) + DW'(IN_X)) : IN_X;
            s_nxt.y1 = s_r.ctrl.xy_off_en ?
                16'(pct(s_r.oy) + DW'(IN_Y)) : IN_Y;
        end

        // ratio input range, only while ratio is in use
        s_nxt.ovf = ratio_on && (AUX1 > AUX_MAX || AUX1 < -AUX_MAX);
        s_nxt.unf = ratio_on && AUX1 < AUX_MIN && AUX1 > -AUX_MIN;
        if (s_r.ctrl.ratio == RAT_AUX2) begin
            s_nxt.ovf = AUX2 > AUX_MAX || AUX2 < -AUX_MAX;
            s_nxt.unf = AUX2 < AUX_MIN && AUX2 > -AUX_MIN;
        end

        // magnitude from ratioed values; expand not yet applied
        rm = mag(xr, yr);
        if (rv) begin
            unique case (s_r.ctrl.dsel)
                Q_R: begin
                    s_nxt.dval = s_r.ctrl.r_off_en ? rm + pct(s_r.roff) : rm;
                    s_nxt.dfs = FS_X;
                    s_nxt.dexp = s_r.exps.r;
                end
                Q_RLOG: begin
                    // plain dB offset, 0.01 dB units
                    s_nxt.dval = s_r.ctrl.rlog_off_en ?
                        lg(rm) + DW'(s_r.loff) : lg(rm);
                    s_nxt.dfs = FS_DB;
                    s_nxt.dexp = s_r.exps.rlog;
                end
                Q_NOISE: begin
                    s_nxt.dval = XNOISE;
                    s_nxt.dfs = FS_X;
                    s_nxt.dexp = s_r.exps.noise;
                end
                Q_AUX1: begin
                    // aux one is shown raw and never expanded
                    s_nxt.dval = DW'(AUX1);
                    s_nxt.dfs = FS_AUX;
                    s_nxt.dexp = EXP_X1;
                end
                Q_X: begin
                    s_nxt.dval = xr;
                    s_nxt.dfs = FS_X;
                    s_nxt.dexp = s_r.exps.x;
                end
                default: begin
                    s_nxt.dval = '0;
                    s_nxt.dfs = FS_X;
                    s_nxt.dexp = EXP_X1;
                end
            endcase
            // output select; x keeps its own settings
            xv = xr;
            s_nxt.aval = s_r.ctrl.out_x ? xv : s_nxt.dval;
            s_nxt.afs = s_r.ctrl.out_x ? FS_X : s_nxt.dfs;
            s_nxt.aexp = s_r.ctrl.out_x ? s_r.exps.x : s_nxt.dexp;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            s_r <= '0;
            s_r.ph.cos_v <= COS_ONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // both quadrature lanes share the divisor
    ratex_ratio u_rat_x (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .vin(s_r.v1),
        .en(ratio_on),
        .num(s_r.x1),
        .den(aux_sel),
        .vout(rv),
        .q(xr)
    );
    ratex_ratio u_rat_y (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .vin(s_r.v1),
        .en(ratio_on),
        .num(s_r.y1),
        .den(aux_sel),
        .vout(),
        .q(yr)
    );

    // display path judges overload against its own expand
    ratex_expand u_exp_disp (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .val(s_r.dval),
        .expand(s_r.dexp),
        .fs(s_r.dfs),
        .code(disp_code_unused),
        .out_overload_flag(disp_out_overload_flag_unused),
        .disp_overload_flag(DISP_OVERLOAD_FLAG)
    );
    ratex_expand u_exp_ana (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .val(s_r.aval),
        .expand(s_r.aexp),
        .fs(s_r.afs),
        .code(CHANNEL_ONE_ANALOG_OUT),
        .out_overload_flag(OUT_OVERLOAD_FLAG),
        .disp_overload_flag(ana_disp_overload_flag_unused)
    );

    // the noise stage is fed the ratioed values
    assign RATIO_VALID = rv;
    assign RATIO_X = xr;
    assign RATIO_Y = yr;
    assign DISP_VALUE = s_r.dval;
    assign DISP_EXPAND = s_r.dexp != EXP_X1;
    assign DISP_EXTRA_DIGITS = s_r.dexp;
    // indicators follow the displayed quantity's expand
    assign X10_LED = s_r.dexp == EXP_X10;
    assign X100_LED = s_r.dexp == EXP_X100;
    // ratio source indicators, channel two mirrors
    assign RATIO_AUX1_LED = s_r.ctrl.ratio == RAT_AUX1;
    assign RATIO_AUX2_LED = s_r.ctrl.ratio == RAT_AUX2;
    assign CH2_AUX1_LED = RATIO_AUX1_LED;
    assign CH2_AUX2_LED = RATIO_AUX2_LED;
    assign RATIO_OVERFLOW = s_r.ovf;
    assign RATIO_UNDERFLOW = s_r.unf;
    assign QUAD_OFFSET_ACTIVE_FLAG = s_r.ctrl.xy_off_en &&
        (s_r.ctrl.dsel == Q_X || s_r.ctrl.dsel == Q_R ||
         s_r.ctrl.dsel == Q_RLOG);
    assign BVALID = s_r.wst == BUS_RESP;
    assign BRESP = s_r.bresp;
    assign RVALID = s_r.rst == BUS_RESP;
    assign RRESP = s_r.rresp;
    assign RDATA = s_r.rdata;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence aux1_high;
        s_r.ctrl.ratio == RAT_AUX1 && AUX1 > AUX_MAX;
    endsequence
    sequence aux_tiny;
        ratio_on && aux_sel < AUX_MIN && aux_sel > -AUX_MIN;
    endsequence

    chk_ratio_overflow: assert property (aux1_high |=> RATIO_OVERFLOW)
        else $error("overflow flag missed");
    chk_ratio_underflow: assert property (aux_tiny |=> RATIO_UNDERFLOW)
        else $error("underflow flag missed");
    chk_flags_idle_off: assert property (
        !ratio_on && $stable(s_r.ctrl) |=> !RATIO_OVERFLOW && !RATIO_UNDERFLOW)
        else $error("ratio flags lit with ratio off");
    chk_ratio_leds_off: assert property (!ratio_on |->
        !RATIO_AUX1_LED && !RATIO_AUX2_LED && !CH2_AUX1_LED && !CH2_AUX2_LED)
        else $error("ratio indicator lit while ratio off");
    chk_expand_leds: assert property (s_r.dexp == EXP_X1 |->
        !X10_LED && !X100_LED && !DISP_EXPAND)
        else $error("expand indicator lit at x1");
    chk_ratio_latency: assert property (s_r.v1 |=> rv)
        else $error("ratio stage lost a sample");
    chk_offset_pair: assert property (IN_VALID && !s_r.ctrl.xy_off_en
        |=> s_r.x1 == $past(IN_X) && s_r.y1 == $past(IN_Y))
        else $error("offset applied while pair disabled");
    // a status write is answered next cycle and refused
    chk_bus_answer: assert property (do_wr && AWADDR == A_STAT
        |=> BVALID && BRESP == RESP_ERR)
        else $error("status write not refused next cycle");
    chk_aux1_unexpanded: assert property (
        rv && s_r.ctrl.dsel == Q_AUX1 |=> s_r.dval == DW'($past(AUX1)))
        else $error("aux one display was altered");
endmodule

// ### test/ratex_dac_model.sv
// output converter model: turns the output code into a held level
module ratex_dac_model (
    input wire logic clk,
    input wire logic signed [15:0] code,
    output logic signed [15:0] mv
);
    timeunit 1ns;
    timeprecision 1ns;
    // the converter settles one clock behind the code it is given
    always @(posedge clk) begin
        mv <= code;
    end
endmodule

// ### test/ratex_chain_tb.sv
// self-checking bench of the ratio/expand output chain
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t: output mismatch", $time); end end
module ratex_chain_tb import ratex_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic iv = 0, awr, wrd, bv, arr, rv, rvl;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdd, rdat;
    logic [1:0] br, rr, resp;
    logic signed [15:0] ix = 0, iy = 0, a1 = 0, a2 = 0, code, mv;
    logic signed [DW-1:0] rx, ry, dv;
    logic [13:0] f;
    int num_errors = 0, tests_run = 0;
    // 20 MHz sample clock
    always #25 clk = ~clk;
    // noise input is fed from the ratioed x, as the noise stage would be
    ratex_chain DUT (.REF_CLK(clk), .RSTN(rstn), .AWADDR(awa), .AWVALID(awv),
        .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrd),
        .BRESP(br), .BVALID(bv), .BREADY(bry), .ARADDR(ara), .ARVALID(arv),
        .ARREADY(arr), .RDATA(rdd), .RRESP(rr), .RVALID(rv), .RREADY(rry),
        .IN_VALID(iv), .IN_X(ix), .IN_Y(iy), .AUX1(a1), .AUX2(a2),
        .XNOISE(rx), .RATIO_VALID(rvl), .RATIO_X(rx), .RATIO_Y(ry),
        .CHANNEL_ONE_ANALOG_OUT(code), .OUT_OVERLOAD_FLAG(f[4]),
        .DISP_VALUE(dv), .DISP_OVERLOAD_FLAG(f[3]), .DISP_EXPAND(f[2]),
        .DISP_EXTRA_DIGITS(f[13:12]), .X10_LED(f[0]), .X100_LED(f[1]),
        .RATIO_AUX1_LED(f[5]), .RATIO_AUX2_LED(f[6]), .CH2_AUX1_LED(f[7]),
        .CH2_AUX2_LED(f[8]), .RATIO_OVERFLOW(f[9]), .RATIO_UNDERFLOW(f[10]),
        .QUAD_OFFSET_ACTIVE_FLAG(f[11]));
    ratex_dac_model conv (.clk(clk), .code(code), .mv(mv));
    // one bus access; write address and data go out together
    task automatic ax(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        if (w) {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        else {ara, arv, rry} <= {a, 2'b11};
        if (w) do @(posedge clk); while (!(awr && wrd));
        else do @(posedge clk); while (!arr);
        {awv, wv, arv} <= 3'b000;
        if (w) do @(posedge clk); while (!bv);
        else do @(posedge clk); while (!rv);
        {resp, rdat} = w ? {br, 32'h0} : {rr, rdd};
        {bry, rry} <= 2'b00;
    endtask
    // one sample in; outputs are compared once the pipe has settled
    task automatic go(input logic signed [15:0] sx, sy, xa, xb,
        input logic signed [DW-1:0] ex, ed, input logic signed [15:0] ea,
        input logic [13:0] ef);
        @(posedge clk);
        {ix, iy, a1, a2, iv} <= {sx, sy, xa, xb, 1'b1};
        @(posedge clk);
        iv <= 1'b0;
        // ratio-valid stands for exactly one cycle after the offset stage
        repeat (2) @(posedge clk);
        `CHK(rvl, 1'b1)
        repeat (4) @(posedge clk);
        `CHK({rx, dv, mv, f, rvl}, {ex, ed, ea, ef, 1'b0})
    endtask
    // register checks, then sample scenarios in order
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        ax(0, A_CTRL, 32'h0);
        `CHK({resp, rdat}, {RESP_OK, 32'h0})
        ax(0, 8'h20, 32'h0);
        `CHK({resp, rdat}, {RESP_ERR, 32'h0})
        ax(1, A_STAT, 32'h1f);
        `CHK(resp, RESP_ERR)
        go(8192,0,1000,1000,8192,8192,5000,14'h0);
        ax(1, A_XOFF, 32'hfffff63c);
        ax(1, A_YOFF, 32'hfffff63c);
        ax(1, A_CTRL, 32'h4);
        go(8192,8192,1000,1000,4096,4096,2500,14'h800);
        `CHK(ry, 4096)
        ax(1, A_CTRL, 32'h5);
        go(8192,8192,1000,1000,4096,4096,2500,14'h8a0);
        go(8192,8192,2000,1000,2048,2048,1250,14'h8a0);
        go(8192,8192,-40,1,-102400,-102400,-10500,14'hcb8);
        go(4096,4096,10600,1000,0,0,0,14'haa0);
        ax(1, A_CTRL, 32'h2);
        go(8192,0,40,2000,4096,4096,2500,14'h140);
        ax(1, A_EXP, 32'h4);
        ax(1, A_CTRL, 32'h1a);
        go(8192,0,1000,2000,4096,4096,2500,14'h114d);
        ax(1, A_CTRL, 32'h12);
        go(8192,0,1000,2000,4096,4096,10500,14'h115d);
        ax(1, A_EXP, 32'h2);
        ax(1, A_CTRL, 32'h0);
        go(-256,0,1000,1000,-256,-256,-10500,14'h201e);
        ax(1, A_CTRL, 32'h10);
        go(-256,0,1000,1000,-256,256,156,14'h0);
        ax(1, A_EXP, 32'h0);
        ax(1, A_CTRL, 32'h41);
        go(8192,0,2000,1000,4096,2000,2000,14'h0a0);
        ax(1, A_CTRL, 32'h31);
        go(8192,0,2000,1000,4096,4096,2500,14'h0a0);
        ax(1, A_LOFF, 32'hffffff1e);
        ax(1, A_CTRL, 32'h120);
        go(8192,0,1000,1000,8192,7600,3800,14'h0);
        ax(1, A_PHASE, 32'h40000000);
        ax(1, A_CTRL, 32'h4);
        go(8192,8192,1000,1000,4096,4096,2500,14'h800);
        `CHK(ry, 12288)
        ax(0, A_PHASE, 32'h0);
        `CHK({resp, rdat}, {RESP_OK, 32'h40000000})
        summarize();
    end
    // the sequence needs about 10 us; a hang ends the run here
    initial begin
        #50us;
        num_errors++;
        summarize();
    end
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
endmodule
